// ===== verilog/fptc_unit.sv
// fp transcendental and control unit: reduction, scale, domain checks, state ops
`timescale 1ns/10ps
module fptc_unit
  import fptc_pkg::*;
#(
  parameter int          STACK_DEPTH = 8,
  parameter logic [16:0] RED_MAX_UE  = 17'h0003f
)(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // instruction request from the integer unit
  input  wire logic        i_req_valid,
  input  wire fptc_req_t   i_req,
  output logic             o_req_ready,
  // completion
  output logic             o_rsp_valid,
  output fptc_rsp_t        o_rsp,
  // word-serial memory port
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [WW-1:0]    o_mem_addr,
  output logic [WW-1:0]    o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [WW-1:0] i_mem_rdata
);

  localparam logic [5:0] WIX_LAST = 6'(WIX_STK + REG_WORDS * STACK_DEPTH - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_REDUCE, ST_MEM} fptc_state_t;

  fptc_state_t      state_q, state_d;
  fptc_op_t         op_q, op_d;
  logic [15:0]      cw_q, cw_d, sw_q, sw_d, tw_q, tw_d;
  logic [XW-1:0]    stk_q [STACK_DEPTH];
  logic [XW-1:0]    stk_d [STACK_DEPTH];
  logic             sign_q, sign_d;
  logic             ready_q, ready_d, rsp_valid_q, rsp_valid_d;
  fptc_rsp_t        rsp_q, rsp_d;
  logic             mreq_q, mreq_d, mwe_q, mwe_d;
  logic [WW-1:0]    maddr_q, maddr_d, mwdata_q, mwdata_d;
  logic [5:0]       idx_q, idx_d, last_q, last_d;
  logic             acc, pend, red_start, red_done, mem_go, mem_wr;
  logic [5:0]       mem_first, mem_last;
  logic [PI_W-1:0]  red_rem;
  logic [14:0]      a_exp;
  logic [63:0]      a_mant;
  logic signed [16:0] ue;
  logic signed [17:0] scl;
  logic [7:0]       red_steps;

  assign acc    = i_req_valid && ready_q;
  assign pend   = |(sw_q[5:0] & ~cw_q[5:0]);
  assign a_exp  = i_req.a[78:64];
  assign a_mant = i_req.a[63:0];
  // unbiased exponent k of the operand, the ulp scale is 2^(k-63)
  assign ue     = signed'({2'b00, a_exp}) - signed'({2'b00, EXP_BIAS});
  assign scl    = signed'({3'b000, a_exp}) + signed'({{2{i_req.b[15]}}, i_req.b[15:0]});
  assign red_steps = 8'(ue + 17'sd66);

  fptc_reduce u_reduce (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_start   (red_start),
    .i_mant    (a_mant),
    .i_steps   (red_steps),
    .o_done    (red_done),
    .o_rem     (red_rem)
  );

  function automatic logic [WW-1:0] word_of(input logic [5:0] ix);
    logic [5:0] off;
    off = ix - WIX_STK;
    if (ix == WIX_CW) word_of = cw_q;
    else if (ix == WIX_SW) word_of = sw_q;
    else if (ix == WIX_TW) word_of = tw_q;
    else word_of = stk_q[3'(off / REG_WORDS)][(off % REG_WORDS) * WW +: WW];
  endfunction

  always_comb begin
    logic [5:0] off;
    off         = idx_q - WIX_STK;
    state_d     = state_q;
    op_d        = op_q;
    cw_d        = cw_q;
    sw_d        = sw_q;
    tw_d        = tw_q;
    stk_d       = stk_q;
    sign_d      = sign_q;
    ready_d     = ready_q;
    rsp_valid_d = 1'b0;
    rsp_d       = rsp_q;
    mreq_d      = mreq_q;
    mwe_d       = mwe_q;
    maddr_d     = maddr_q;
    mwdata_d    = mwdata_q;
    idx_d       = idx_q;
    last_d      = last_q;
    red_start   = 1'b0;
    mem_go      = 1'b0;
    mem_wr      = 1'b0;
    mem_first   = WIX_CW;
    mem_last    = WIX_CW;
    case (state_q)
      ST_IDLE: begin
        if (acc) begin
          op_d        = i_req.op;
          sign_d      = i_req.a[SIGN_BIT];
          rsp_d       = '0;
          rsp_valid_d = 1'b1;
          if (!i_req.nowait && pend) begin
            rsp_d.fault = 1'b1;
          end else begin
            case (i_req.op)
              OP_INIT: begin
                cw_d = CW_INIT;
                sw_d = SW_INIT;
                tw_d = TW_INIT;
                for (int i = 0; i < STACK_DEPTH; i++) stk_d[i] = '0;
              end
              OP_CLEX: sw_d[5:0] = 6'h00;
              OP_LDCW: mem_go = 1'b1;
              OP_STCW: begin
                mem_go = 1'b1;
                mem_wr = 1'b1;
              end
              OP_STSW: begin
                if (i_req.to_gpr) begin
                  rsp_d.data = XW'(sw_q);
                end else begin
                  mem_go    = 1'b1;
                  mem_wr    = 1'b1;
                  mem_first = WIX_SW;
                  mem_last  = WIX_SW;
                end
              end
              OP_LDENV, OP_STENV, OP_RSTOR, OP_SAVE: begin
                mem_go   = 1'b1;
                mem_wr   = (i_req.op == OP_STENV) || (i_req.op == OP_SAVE);
                mem_last = ((i_req.op == OP_LDENV) || (i_req.op == OP_STENV)) ? WIX_TW
                                                                              : WIX_LAST;
              end
              OP_SIN, OP_COS, OP_SINCOS, OP_TAN: begin
                rsp_d.data = i_req.a;
                // signed compare: a small operand has a negative exponent
                if (a_exp == 15'h0000 || ue < signed'(17'(RED_MIN_UE))) begin
                  sw_d[SW_C2] = 1'b0;
                end else if (ue > signed'(RED_MAX_UE)) begin
                  sw_d[SW_C2] = 1'b1;
                end else begin
                  sw_d[SW_C2] = 1'b0;
                  red_start   = 1'b1;
                  rsp_valid_d = 1'b0;
                  state_d     = ST_REDUCE;
                end
              end
              OP_SCALE: begin
                rsp_d.data = i_req.a;
                if (a_exp != 15'h0000 && a_exp != EXP_ALL1) begin
                  if (scl >= signed'({3'b000, EXP_ALL1})) begin
                    rsp_d.data = {i_req.a[SIGN_BIT], EXP_ALL1, MANT_ONE};
                    sw_d[FLG_OVF] = 1'b1;
                  end else if (scl <= 18'sd0) begin
                    rsp_d.data = {i_req.a[SIGN_BIT], 79'h0};
                    sw_d[FLG_UNF] = 1'b1;
                  end else begin
                    rsp_d.data[78:64] = scl[14:0];
                  end
                end
              end
              OP_EXP2M1: begin
                rsp_d.data = i_req.a;
                if (a_exp > EXP_BIAS || (a_exp == EXP_BIAS && a_mant != MANT_ONE)) begin
                  sw_d[FLG_INV] = 1'b1;
                end else begin
                  sw_d[FLG_PREC] = 1'b1;
                end
              end
              OP_LOG2, OP_LOG2P1: begin
                rsp_d.data = XW'(ue);
                if (i_req.op == OP_LOG2 ? (i_req.a[SIGN_BIT] || a_exp == 15'h0000)
                    : (i_req.a[SIGN_BIT] && a_exp >= EXP_BIAS)) begin
                  sw_d[FLG_INV] = 1'b1;
                end
              end
              default: ;
            endcase
          end
          if (mem_go) begin
            rsp_valid_d = 1'b0;
            state_d     = ST_MEM;
            mreq_d      = 1'b1;
            mwe_d       = mem_wr;
            maddr_d     = i_req.addr;
            idx_d       = mem_first;
            last_d      = mem_last;
            mwdata_d    = word_of(mem_first);
          end
          ready_d = rsp_valid_d;
        end
      end
      ST_REDUCE: begin
        if (red_done) begin
          rsp_d.data  = {sign_q, 11'h000, red_rem};
          rsp_d.fixed = 1'b1;
          rsp_valid_d = 1'b1;
          ready_d     = 1'b1;
          state_d     = ST_IDLE;
        end
      end
      ST_MEM: begin
        if (i_mem_ack) begin
          if (!mwe_q) begin
            if (idx_q == WIX_CW) cw_d = i_mem_rdata;
            else if (idx_q == WIX_SW) sw_d = i_mem_rdata;
            else if (idx_q == WIX_TW) tw_d = i_mem_rdata;
            else stk_d[3'(off / REG_WORDS)][(off % REG_WORDS) * WW +: WW] = i_mem_rdata;
          end
          if (idx_q == last_q) begin
            mreq_d      = 1'b0;
            rsp_valid_d = 1'b1;
            ready_d     = 1'b1;
            state_d     = ST_IDLE;
            if (op_q == OP_SAVE) begin
              cw_d = CW_INIT;
              sw_d = SW_INIT;
              tw_d = TW_INIT;
              for (int i = 0; i < STACK_DEPTH; i++) stk_d[i] = '0;
            end
          end else begin
            idx_d    = idx_q + 6'h01;
            maddr_d  = maddr_q + 16'h0001;
            mwdata_d = word_of(idx_q + 6'h01);
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // summary bit follows the unmasked flags
    sw_d[SW_ES] = |(sw_d[5:0] & ~cw_d[5:0]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NOP;
      cw_q        <= CW_INIT;
      sw_q        <= SW_INIT;
      tw_q        <= TW_INIT;
      for (int i = 0; i < STACK_DEPTH; i++) stk_q[i] <= '0;
      sign_q      <= 1'b0;
      ready_q     <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
      mreq_q      <= 1'b0;
      mwe_q       <= 1'b0;
      maddr_q     <= '0;
      mwdata_q    <= '0;
      idx_q       <= '0;
      last_q      <= '0;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      cw_q        <= cw_d;
      sw_q        <= sw_d;
      tw_q        <= tw_d;
      stk_q       <= stk_d;
      sign_q      <= sign_d;
      ready_q     <= (state_q == ST_IDLE && !acc) ? 1'b1 : ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q       <= rsp_d;
      mreq_q      <= mreq_d;
      mwe_q       <= mwe_d;
      maddr_q     <= maddr_d;
      mwdata_q    <= mwdata_d;
      idx_q       <= idx_d;
      last_q      <= last_d;
    end
  end

  assign o_req_ready = ready_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp       = rsp_q;
  assign o_mem_req   = mreq_q;
  assign o_mem_we    = mwe_q;
  assign o_mem_addr  = maddr_q;
  assign o_mem_wdata = mwdata_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_pending_fault;
    acc && !i_req.nowait && pend |=> o_rsp_valid && o_rsp.fault;
  endproperty
  a_pending_fault: assert property (p_pending_fault) else $error("pending fault missed");

  property p_nowait_init;
    acc && i_req.nowait && i_req.op == OP_INIT |=> !o_rsp.fault && cw_q == CW_INIT
      && tw_q == TW_INIT;
  endproperty
  a_nowait_init: assert property (p_nowait_init) else $error("nowait init wrong");

  property p_init_sw;
    acc && (i_req.nowait || !pend) && i_req.op == OP_INIT |=> sw_q == SW_INIT;
  endproperty
  a_init_sw: assert property (p_init_sw) else $error("init status not cleared");

  property p_save_reinit;
    o_rsp_valid && op_q == OP_SAVE && !o_rsp.fault |-> cw_q == CW_INIT && tw_q == TW_INIT;
  endproperty
  a_save_reinit: assert property (p_save_reinit) else $error("save did not reinit");

  property p_scale_by_one;
    acc && !pend && i_req.op == OP_SCALE && a_exp == EXP_BIAS && i_req.b[15:0] == 16'h0001
      |=> o_rsp.data[78:64] == 15'h4000;
  endproperty
  a_scale_by_one: assert property (p_scale_by_one) else $error("scale exponent wrong");

  property p_exp_domain;
    acc && !pend && i_req.op == OP_EXP2M1 && a_exp > EXP_BIAS |=> sw_q[FLG_INV];
  endproperty
  a_exp_domain: assert property (p_exp_domain) else $error("exp2 domain not flagged");

  property p_rem_in_period;
    red_done |-> red_rem < PI_FRAC ##1 o_rsp_valid && o_rsp.fixed;
  endproperty
  a_rem_in_period: assert property (p_rem_in_period) else $error("remainder not reduced");

  property p_stsw_gpr;
    acc && !pend && i_req.op == OP_STSW && i_req.to_gpr |=> o_rsp_valid
      && o_rsp.data[15:0] == $past(sw_q);
  endproperty
  a_stsw_gpr: assert property (p_stsw_gpr) else $error("status to gpr wrong");

  property p_mem_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");

  c_save_done:  cover property (o_rsp_valid && op_q == OP_SAVE);
  c_reduced:    cover property (o_rsp_valid && o_rsp.fixed);
  c_fault:      cover property (o_rsp_valid && o_rsp.fault);
  c_restore:    cover property (o_rsp_valid && op_q == OP_RSTOR);

endmodule // fptc_unit

// ===== verilog/fptc_pkg.sv
// package: constants, commands and carriers of the fp transcendental and control unit
package fptc_pkg;

  // operand layout: sign, biased exponent, explicit-integer significand
  localparam int          XW           = 80;
  localparam int          MW           = 64;
  localparam int          WW           = 16;
  localparam int          SIGN_BIT     = 79;
  localparam int          EXP_LSB      = 64;
  localparam logic [14:0] EXP_BIAS     = 15'h3fff;
  localparam logic [14:0] EXP_ALL1     = 15'h7fff;
  localparam logic [63:0] MANT_ONE     = 64'h8000_0000_0000_0000;

  // internal pi: 0.f * 2^2, f given as 68 fraction bits (66 significant)
  localparam int          PI_W         = 68;
  localparam logic [67:0] PI_FRAC      = 68'hc90fdaa22168c234c;
  // in units of 2^-65 the same bit string is 2*pi; x needs 2 extra shift steps
  localparam int          RED_XTRA     = 2;
  localparam int          RED_MIN_UE   = 2;

  // status and control word fields
  localparam int          FLG_INV      = 0;
  localparam int          FLG_OVF      = 3;
  localparam int          FLG_UNF      = 4;
  localparam int          FLG_PREC     = 5;
  localparam int          SW_ES        = 7;
  localparam int          SW_C2        = 10;
  localparam logic [15:0] CW_INIT      = 16'h003f;
  localparam logic [15:0] SW_INIT      = 16'h0000;
  localparam logic [15:0] TW_INIT      = 16'hffff;

  // save-area word indices: control, status, tag, then stack registers
  localparam logic [5:0]  WIX_CW       = 6'h00;
  localparam logic [5:0]  WIX_SW       = 6'h01;
  localparam logic [5:0]  WIX_TW       = 6'h02;
  localparam logic [5:0]  WIX_STK      = 6'h03;
  localparam logic [5:0]  REG_WORDS    = 6'h05;

  typedef enum logic [4:0] {
    OP_NOP, OP_INIT, OP_LDCW, OP_STCW, OP_STSW, OP_CLEX, OP_LDENV, OP_STENV,
    OP_RSTOR, OP_SAVE, OP_WAIT, OP_SIN, OP_COS, OP_SINCOS, OP_TAN,
    OP_LOG2, OP_LOG2P1, OP_EXP2M1, OP_SCALE
  } fptc_op_t;

  typedef struct packed {
    fptc_op_t         op;
    logic             nowait;
    logic             to_gpr;
    logic [15:0]      addr;
    logic [XW-1:0]    a;
    logic [XW-1:0]    b;
  } fptc_req_t;

  typedef struct packed {
    logic [XW-1:0]    data;
    logic             fixed;
    logic             fault;
  } fptc_rsp_t;

endpackage

// ===== verilog/fptc_reduce.sv
// bit-serial remainder of x modulo the internal 2*pi
`timescale 1ns/10ps
module fptc_reduce
  import fptc_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_srst,
  // start with significand and step count
  input  wire logic              i_start,
  input  wire logic [MW-1:0]     i_mant,
  input  wire logic [7:0]        i_steps,
  // result, remainder in units of 2^-65
  output logic                   o_done,
  output logic [PI_W-1:0]        o_rem
);

  logic [MW-1:0]   num_q, num_d;
  logic [PI_W-1:0] rem_q, rem_d;
  logic [7:0]      cnt_q, cnt_d;
  logic            run_q, run_d;
  logic            done_q, done_d;
  logic [PI_W:0]   trial;

  // restoring division step against the internal 2*pi, one bit per cycle
  always_comb begin
    num_d  = num_q;
    rem_d  = rem_q;
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    trial  = {rem_q, num_q[MW-1]};
    if (i_start) begin
      num_d = i_mant;
      rem_d = '0;
      cnt_d = i_steps;
      run_d = 1'b1;
    end else if (run_q) begin
      num_d = {num_q[MW-2:0], 1'b0};
      if (trial >= {1'b0, PI_FRAC}) begin
        rem_d = PI_W'(trial - {1'b0, PI_FRAC});
      end else begin
        rem_d = trial[PI_W-1:0];
      end
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      num_q  <= '0;
      rem_q  <= '0;
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      num_q  <= num_d;
      rem_q  <= rem_d;
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
  assign o_rem  = rem_q;

endmodule // fptc_reduce

// ===== bench/fptc_mem_model.sv
// word memory answering the unit's memory port, with a settable ack delay
`timescale 1ns/10ps
module fptc_mem_model
  import fptc_pkg::*;
(
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_srst,
  // memory port from the unit, and the ack delay from the bench
  input  wire logic          i_mem_req,
  input  wire logic          i_mem_we,
  input  wire logic [WW-1:0] i_mem_addr,
  input  wire logic [WW-1:0] i_mem_wdata,
  input  wire logic [3:0]    i_delay,
  output logic               o_mem_ack,
  output logic [WW-1:0]      o_mem_rdata
);
  logic [WW-1:0] mem_q [0:511];
  logic [3:0]    cnt_q;

  // read data is inverted outside the ack cycle so a stale sample cannot pass
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_mem_ack   <= 1'b0;
      cnt_q       <= 4'h0;
      o_mem_rdata <= 16'h0000;
    end else if (o_mem_ack) begin
      o_mem_ack   <= 1'b0;
      cnt_q       <= 4'h0;
      o_mem_rdata <= ~o_mem_rdata;
    end else if (i_mem_req && (cnt_q >= i_delay)) begin
      o_mem_ack <= 1'b1;
      cnt_q     <= 4'h0;
      if (i_mem_we) begin
        mem_q[i_mem_addr[8:0]] <= i_mem_wdata;
      end else begin
        o_mem_rdata <= mem_q[i_mem_addr[8:0]];
      end
    end else if (i_mem_req) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // fptc_mem_model

// ===== bench/fptc_unit_tb.sv
// self-checking bench of the fp transcendental and control unit
`timescale 1ns/10ps
`define FPTC_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, (got), (exp)); end end
module fptc_unit_tb;
  import fptc_pkg::*;
  logic              i_ref_clk;
  logic              i_srst;
  logic              req_valid;
  fptc_req_t         req;
  logic              req_ready;
  logic              rsp_valid;
  fptc_rsp_t         rsp;
  logic              mem_req;
  logic              mem_we;
  logic [WW-1:0]     mem_addr;
  logic [WW-1:0]     mem_wdata;
  logic              mem_ack;
  logic [WW-1:0]     mem_rdata;
  logic [3:0]        delay;
  int                err_count;
  int                check_count;
  int                cycles;

  fptc_unit dut_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
  fptc_mem_model mem_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mem_req(mem_req),
    .i_mem_we(mem_we), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
    .i_delay(delay), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));

  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  task automatic conclude();
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // generous ceiling: the longest sequence is a few hundred cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[ERR] %0t run timed out", $time);
      conclude();
    end
  end

  function automatic logic [XW-1:0] fp(input logic [14:0] e);
    return {1'b0, e, MANT_ONE};
  endfunction

  // present a request until taken, then wait for its completion
  task automatic issue(input fptc_op_t op, input logic nw, input logic gpr,
                       input logic [15:0] ad, input logic [XW-1:0] a, input logic [XW-1:0] b);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    req_valid = 1'b1;
    req = '{op: op, nowait: nw, to_gpr: gpr, addr: ad, a: a, b: b};
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge i_ref_clk);
      n++;
    end
    @(negedge i_ref_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("[ERR] %0t no completion", $time);
    end
  endtask

  task automatic chk_sw(input int bit_ix, input logic exp);
    issue(OP_STSW, 1'b1, 1'b1, 16'h0000, '0, '0);
    `FPTC_CHK(rsp.data[bit_ix], exp)
  endtask

  task automatic t_defaults();
    issue(OP_SAVE, 1'b1, 1'b0, 16'h0000, '0, '0);
    `FPTC_CHK(mem_u.mem_q[0], CW_INIT)
    `FPTC_CHK(mem_u.mem_q[1], SW_INIT)
    `FPTC_CHK(mem_u.mem_q[2], TW_INIT)
    for (int i = 3; i < 43; i++) `FPTC_CHK(mem_u.mem_q[i], 16'h0000)
  endtask

  task automatic t_scale();
    issue(OP_SCALE, 1'b0, 1'b0, 16'h0000, fp(15'h3fff), 80'h3);
    `FPTC_CHK(rsp.data, fp(15'h4002))
    issue(OP_SCALE, 1'b0, 1'b0, 16'h0000, fp(15'h3fff), 80'hffff);
    `FPTC_CHK(rsp.data, fp(15'h3ffe))
  endtask

  task automatic t_trig();
    // 8.0 lies between 2Pi and 4Pi, so exactly one period comes off
    logic [XW-1:0] red;
    red = {1'b0, 11'h000, 68'h36f0255dde973dcb4};
    issue(OP_SIN, 1'b0, 1'b0, 16'h0000, fp(15'h4002), '0);
    `FPTC_CHK(rsp.data, red)
    `FPTC_CHK(rsp.fixed, 1'b1)
    issue(OP_SINCOS, 1'b0, 1'b0, 16'h0000, fp(15'h4002), '0);
    `FPTC_CHK(rsp.data, red)
    // small arguments already pre-reduced by the issuer, then one too large to reduce that sets C2
    issue(OP_COS, 1'b0, 1'b0, 16'h0000, fp(15'h4000), '0);
    `FPTC_CHK(rsp.data, fp(15'h4000))
    issue(OP_SIN, 1'b0, 1'b0, 16'h0000, fp(15'h3ffe), '0);
    `FPTC_CHK(rsp.data, fp(15'h3ffe))
    `FPTC_CHK(rsp.fixed, 1'b0)
    issue(OP_TAN, 1'b0, 1'b0, 16'h0000, fp(15'h403f), '0);
    `FPTC_CHK(rsp.data, fp(15'h403f))
    chk_sw(SW_C2, 1'b1);
  endtask

  task automatic t_exp_log();
    issue(OP_EXP2M1, 1'b0, 1'b0, 16'h0000, fp(15'h3ffe), '0);
    `FPTC_CHK(rsp.data, fp(15'h3ffe))
    chk_sw(FLG_INV, 1'b0);
    issue(OP_EXP2M1, 1'b0, 1'b0, 16'h0000, fp(15'h4000), '0);
    chk_sw(FLG_INV, 1'b1);
    issue(OP_LOG2, 1'b1, 1'b0, 16'h0000, fp(15'h4002), fp(15'h3fff));
    `FPTC_CHK(rsp.data, 80'h3)
    issue(OP_LOG2P1, 1'b1, 1'b0, 16'h0000, fp(15'h3fff), fp(15'h3fff));
    `FPTC_CHK(rsp.fault, 1'b0)
  endtask

  task automatic t_pending();
    mem_u.mem_q[400] = 16'h0000;
    issue(OP_LDCW, 1'b0, 1'b0, 16'd400, '0, '0);
    issue(OP_WAIT, 1'b0, 1'b0, 16'h0000, '0, '0);
    `FPTC_CHK(rsp.fault, 1'b1)
    issue(OP_SCALE, 1'b0, 1'b0, 16'h0000, fp(15'h3fff), 80'h1);
    `FPTC_CHK(rsp.fault, 1'b1)
    issue(OP_SCALE, 1'b1, 1'b0, 16'h0000, fp(15'h3fff), 80'h1);
    `FPTC_CHK(rsp.fault, 1'b0)
    `FPTC_CHK(rsp.data, fp(15'h4000))
    issue(OP_STCW, 1'b1, 1'b0, 16'd401, '0, '0);
    `FPTC_CHK(mem_u.mem_q[401], 16'h0000)
    issue(OP_CLEX, 1'b1, 1'b0, 16'h0000, '0, '0);
    issue(OP_STSW, 1'b1, 1'b1, 16'h0000, '0, '0);
    `FPTC_CHK(rsp.data[7:0], 8'h00)
    issue(OP_WAIT, 1'b0, 1'b0, 16'h0000, '0, '0);
    `FPTC_CHK(rsp.fault, 1'b0)
    issue(OP_STSW, 1'b0, 1'b0, 16'd402, '0, '0);
    `FPTC_CHK(mem_u.mem_q[402][7:0], 8'h00)
  endtask

  task automatic t_restore();
    // status word stays clear in the images so no exception is pending
    for (int i = 0; i < 43; i++) mem_u.mem_q[100 + i] = 16'h1000 + 16'(i);
    mem_u.mem_q[101] = 16'h0000;
    mem_u.mem_q[150] = 16'h0001;
    mem_u.mem_q[151] = 16'h0000;
    mem_u.mem_q[152] = 16'h1234;
    delay = 4'h3;
    issue(OP_RSTOR, 1'b0, 1'b0, 16'd100, '0, '0);
    issue(OP_SAVE, 1'b1, 1'b0, 16'd200, '0, '0);
    for (int i = 0; i < 43; i++) `FPTC_CHK(mem_u.mem_q[200 + i], mem_u.mem_q[100 + i])
    issue(OP_STENV, 1'b1, 1'b0, 16'd300, '0, '0);
    `FPTC_CHK(mem_u.mem_q[300], CW_INIT)
    `FPTC_CHK(mem_u.mem_q[301], SW_INIT)
    `FPTC_CHK(mem_u.mem_q[302], TW_INIT)
    issue(OP_LDENV, 1'b0, 1'b0, 16'd150, '0, '0);
    issue(OP_STENV, 1'b0, 1'b0, 16'd160, '0, '0);
    for (int i = 0; i < 3; i++) `FPTC_CHK(mem_u.mem_q[160 + i], mem_u.mem_q[150 + i])
    issue(OP_INIT, 1'b1, 1'b0, 16'h0000, '0, '0);
    issue(OP_STCW, 1'b0, 1'b0, 16'd170, '0, '0);
    `FPTC_CHK(mem_u.mem_q[170], CW_INIT)
    delay = 4'h0;
  endtask

  initial begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    delay = 4'h0;
    req_valid = 1'b0;
    req = '0;
    i_srst = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_srst = 1'b0;
    t_defaults();
    t_scale();
    t_trig();
    t_exp_log();
    t_pending();
    t_restore();
    conclude();
  end
endmodule // fptc_unit_tb
